// ==== verilog/obcd_pkg.sv ====
// Constants and types for the option byte configuration decoder
package obcd_pkg;

   // Register byte offsets on the Avalon-MM slave
   localparam logic [4:0] ADDR_OPT_BYTE0 = 5'h00;
   localparam logic [4:0] ADDR_OPT_BYTE1 = 5'h04;
   localparam logic [4:0] ADDR_COMMAND = 5'h08;
   localparam logic [4:0] ADDR_STATUS = 5'h0C;
   localparam logic [4:0] ADDR_APPLIED = 5'h10;

   // Erased non-volatile byte
   localparam logic [7:0] NV_ERASED = 8'hFF;

   // Option byte 0 field positions
   localparam int B0_HALT_WDG_RST = 7;
   localparam int B0_WDG_TYPE = 6;
   localparam int B0_VD_HI = 4;
   localparam int B0_VD_LO = 3;
   localparam int B0_PKG_LO = 1;
   localparam int B0_READOUT = 0;

   // Option byte 1 field positions
   localparam int B1_PKG_HI = 7;
   localparam int B1_RST_DELAY = 6;
   localparam int B1_OSC_SRC_HI = 5;
   localparam int B1_OSC_SRC_LO = 4;
   localparam int B1_OSC_RNG_HI = 3;
   localparam int B1_OSC_RNG_LO = 1;
   localparam int B1_PLL_OFF = 0;

   // Command register bits
   localparam int CMD_ERASE = 0;

   // Status register bits
   localparam int ST_PROG_MODE = 0;
   localparam int ST_ERASE_BUSY = 1;
   localparam int ST_USER_ERASE = 2;
   localparam int ST_PROTECT = 3;
   localparam int ST_RUNNING = 4;

   // Voltage detector threshold codes
   localparam logic [1:0] VD_OFF = 2'h3;
   localparam logic [1:0] VD_LOWEST = 2'h2;
   localparam logic [1:0] VD_MEDIUM = 2'h1;
   localparam logic [1:0] VD_HIGHEST = 2'h0;

   // Oscillator source codes
   localparam logic [1:0] OSC_RESONATOR = 2'h0;
   localparam logic [1:0] OSC_RESERVED = 2'h1;
   localparam logic [1:0] OSC_INTERNAL_RC = 2'h2;
   localparam logic [1:0] OSC_EXTERNAL = 2'h3;

   // Oscillator range codes
   localparam logic [2:0] RANGE_1_2MHZ = 3'h0;
   localparam logic [2:0] RANGE_2_4MHZ = 3'h1;
   localparam logic [2:0] RANGE_4_8MHZ = 3'h2;
   localparam logic [2:0] RANGE_8_16MHZ = 3'h3;

   // Package code for the 80-lead package
   localparam logic [1:0] PKG_80_LEAD = 2'h3;

   // Pads per port and port count
   localparam int PADS_PER_PORT = 8;
   localparam int NUM_PORTS = 8;
   localparam int NUM_PADS = PADS_PER_PORT * NUM_PORTS;

   // Bonded pad maps for the 80-lead package and for the other packages
   localparam logic [63:0] BOND_MAP_80 = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] BOND_MAP_OTHER = 64'h0000_0000_0000_0000;

   // Reset phase lengths in CPU cycles
   localparam logic [12:0] RST_CYCLES_LONG = 13'h1000;
   localparam logic [12:0] RST_CYCLES_SHORT = 13'h0100;

   // Sequencer states, one-hot
   typedef enum logic [4:0] {
      SEQ_LOAD = 5'h01,
      SEQ_DELAY = 5'h02,
      SEQ_RUN = 5'h04,
      SEQ_USER_ERASE = 5'h08,
      SEQ_OPT_ERASE = 5'h10
   } obcd_state_t;

   // Decoded static settings
   typedef struct packed {
      logic halt_wdg_reset_en;
      logic wdg_hw_enabled;
      logic vd_enabled;
      logic [1:0] vd_threshold;
      logic readout_protected;
      logic [1:0] package_sel;
      logic package_80;
      logic long_reset_delay;
      logic [1:0] osc_source;
      logic [2:0] osc_range;
      logic pll_enabled;
   } obcd_cfg_t;

endpackage

// ==== verilog/obcd_decoder.sv ====
// Option byte store, reset-time loader and decoder with Avalon-MM access
`timescale 1ns/10ps

module obcd_decoder (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_power_on,
   input wire logic i_prog_mode,
   input wire logic i_halt_entry,
   input wire logic i_wdg_running,
   input wire logic i_halt_exit,
   input wire logic i_user_erase_done,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output obcd_pkg::obcd_cfg_t o_cfg,
   output logic o_cpu_reset_n,
   output logic o_halt_exit_wait,
   output logic o_halt_watchdog_reset_select_reset,
   output logic o_user_erase_req,
   output logic [63:0] o_pad_pullup
);

   // Non-volatile option byte store
   logic [7:0] nv_byte_r [2];
   obcd_pkg::obcd_state_t state_r;
   obcd_pkg::obcd_state_t state_nxt;
   obcd_pkg::obcd_cfg_t cfg_r;
   logic [12:0] delay_cnt_r;
   logic [12:0] halt_cnt_r;
   logic prog_meta_r;
   logic prog_sync_r;
   logic waitreq_r;
   logic [31:0] rdata_r;
   logic cpu_reset_n_r;
   logic halt_wait_r;
   logic halt_watchdog_reset_select_rst_r;
   logic user_erase_r;
   logic [63:0] pullup_r;
   logic erase_pending_r;
   logic bus_req;
   logic bus_commit;
   logic opt_access;
   logic [12:0] delay_len;

   // Byte-wide decode of the option bytes into settings
   function automatic obcd_pkg::obcd_cfg_t decode_cfg(input logic [7:0] b0,
                                                     input logic [7:0] b1);
      obcd_pkg::obcd_cfg_t c;
      c.halt_wdg_reset_en = b0[obcd_pkg::B0_HALT_WDG_RST];
      c.wdg_hw_enabled = ~b0[obcd_pkg::B0_WDG_TYPE];
      c.vd_threshold = b0[obcd_pkg::B0_VD_HI:obcd_pkg::B0_VD_LO];
      c.vd_enabled = (c.vd_threshold != obcd_pkg::VD_OFF);
      c.readout_protected = ~b0[obcd_pkg::B0_READOUT];
      c.package_sel = {b1[obcd_pkg::B1_PKG_HI], b0[obcd_pkg::B0_PKG_LO]};
      c.package_80 = (c.package_sel == obcd_pkg::PKG_80_LEAD);
      c.long_reset_delay = ~b1[obcd_pkg::B1_RST_DELAY];
      c.osc_source = b1[obcd_pkg::B1_OSC_SRC_HI:obcd_pkg::B1_OSC_SRC_LO];
      c.osc_range = b1[obcd_pkg::B1_OSC_RNG_HI:obcd_pkg::B1_OSC_RNG_LO];
      c.pll_enabled = ~b1[obcd_pkg::B1_PLL_OFF];
      return c;
   endfunction

   // Reset or halt-exit length in cycles from the delay select
   function automatic logic [12:0] delay_cycles(input logic long_sel);
      return long_sel ? obcd_pkg::RST_CYCLES_LONG : obcd_pkg::RST_CYCLES_SHORT;
   endfunction

   // Package code from both bytes
   function automatic logic nv_pkg_is_80(input logic [7:0] b0, input logic [7:0] b1);
      return {b1[obcd_pkg::B1_PKG_HI], b0[obcd_pkg::B0_PKG_LO]} == obcd_pkg::PKG_80_LEAD;
   endfunction

   assign bus_req = i_avs_read | i_avs_write;
   assign bus_commit = bus_req & ~waitreq_r;
   assign opt_access = prog_sync_r;
   assign delay_len = delay_cycles(cfg_r.long_reset_delay);

   // Programming mode pin synchroniser
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         prog_meta_r <= 1'b0;
         prog_sync_r <= 1'b0;
      end else begin
         prog_meta_r <= i_prog_mode;
         prog_sync_r <= prog_meta_r;
      end
   end

   // Sequencer next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         obcd_pkg::SEQ_LOAD: begin
            state_nxt = obcd_pkg::SEQ_DELAY;
         end
         obcd_pkg::SEQ_DELAY: begin
            if (delay_cnt_r == 13'h0001) begin
               state_nxt = obcd_pkg::SEQ_RUN;
            end
         end
         obcd_pkg::SEQ_RUN: begin
            if (erase_pending_r) begin
               // protected erase clears user memory first
               if (~nv_byte_r[0][obcd_pkg::B0_READOUT]) begin
                  state_nxt = obcd_pkg::SEQ_USER_ERASE;
               end else begin
                  state_nxt = obcd_pkg::SEQ_OPT_ERASE;
               end
            end
         end
         obcd_pkg::SEQ_USER_ERASE: begin
            if (i_user_erase_done) begin
               state_nxt = obcd_pkg::SEQ_OPT_ERASE;
            end
         end
         obcd_pkg::SEQ_OPT_ERASE: begin
            state_nxt = obcd_pkg::SEQ_RUN;
         end
         default: begin
            state_nxt = obcd_pkg::SEQ_LOAD;
         end
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state_r <= obcd_pkg::SEQ_LOAD;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Option byte store, kept across system reset
   always_ff @(posedge i_mclk) begin
      if (i_power_on) begin
         nv_byte_r[0] <= obcd_pkg::NV_ERASED;
         nv_byte_r[1] <= obcd_pkg::NV_ERASED;
      end else if (state_r == obcd_pkg::SEQ_OPT_ERASE) begin
         nv_byte_r[0] <= obcd_pkg::NV_ERASED;
         nv_byte_r[1] <= obcd_pkg::NV_ERASED;
      end else if (bus_commit & i_avs_write & opt_access & i_avs_byteenable[0]
                   & (state_r == obcd_pkg::SEQ_RUN)) begin
         if (i_avs_address == obcd_pkg::ADDR_OPT_BYTE0) begin
            nv_byte_r[0] <= i_avs_writedata[7:0];
         end
         if (i_avs_address == obcd_pkg::ADDR_OPT_BYTE1) begin
            nv_byte_r[1] <= i_avs_writedata[7:0];
         end
      end
   end

   // Erase command capture
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         erase_pending_r <= 1'b0;
      end else if (bus_commit & i_avs_write & opt_access & i_avs_byteenable[0]
                   & (i_avs_address == obcd_pkg::ADDR_COMMAND)
                   & i_avs_writedata[obcd_pkg::CMD_ERASE]) begin
         erase_pending_r <= 1'b1;
      end else if (state_r != obcd_pkg::SEQ_RUN) begin
         erase_pending_r <= 1'b0;
      end else if (erase_pending_r) begin
         erase_pending_r <= 1'b0;
      end
   end

   // User memory erase request
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         user_erase_r <= 1'b0;
      end else begin
         // hold request until memory reports done
         user_erase_r <= (state_nxt == obcd_pkg::SEQ_USER_ERASE);
      end
   end

   // Applied settings, loaded once per reset
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cfg_r <= decode_cfg(obcd_pkg::NV_ERASED, obcd_pkg::NV_ERASED);
      end else if (state_r == obcd_pkg::SEQ_LOAD) begin
         cfg_r <= decode_cfg(nv_byte_r[0], nv_byte_r[1]);
      end
   end

   // Reset phase counter
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         delay_cnt_r <= obcd_pkg::RST_CYCLES_LONG;
         cpu_reset_n_r <= 1'b0;
      end else if (state_r == obcd_pkg::SEQ_LOAD) begin
         delay_cnt_r <= delay_cycles(~nv_byte_r[1][obcd_pkg::B1_RST_DELAY]);
         cpu_reset_n_r <= 1'b0;
      end else if (state_r == obcd_pkg::SEQ_DELAY) begin
         delay_cnt_r <= delay_cnt_r - 13'h0001;
         cpu_reset_n_r <= (delay_cnt_r == 13'h0001);
      end
   end

   // Halt exit delay
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         halt_cnt_r <= 13'h0000;
         halt_wait_r <= 1'b0;
      end else if (i_halt_exit & ~halt_wait_r & (state_r == obcd_pkg::SEQ_RUN)) begin
         halt_cnt_r <= delay_len;
         halt_wait_r <= 1'b1;
      end else if (halt_wait_r) begin
         halt_cnt_r <= halt_cnt_r - 13'h0001;
         halt_wait_r <= (halt_cnt_r != 13'h0001);
      end
   end

   // Watchdog reset on halt entry
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         halt_watchdog_reset_select_rst_r <= 1'b0;
      end else begin
         // reset only when option set and watchdog running
         halt_watchdog_reset_select_rst_r <= i_halt_entry & i_wdg_running & cfg_r.halt_wdg_reset_en
                           & (state_r == obcd_pkg::SEQ_RUN);
      end
   end

   // Pull-up on unbonded pads
   genvar p;
   generate
      for (p = 0; p < obcd_pkg::NUM_PORTS; p++) begin : g_port
         always_ff @(posedge i_mclk) begin
            if (i_rst) begin
               pullup_r[p*obcd_pkg::PADS_PER_PORT +: obcd_pkg::PADS_PER_PORT]
                  <= {obcd_pkg::PADS_PER_PORT{1'b1}};
            end else if (state_r == obcd_pkg::SEQ_LOAD) begin
               pullup_r[p*obcd_pkg::PADS_PER_PORT +: obcd_pkg::PADS_PER_PORT]
                  <= nv_pkg_is_80(nv_byte_r[0], nv_byte_r[1])
                  ? ~obcd_pkg::BOND_MAP_80[p*obcd_pkg::PADS_PER_PORT +: obcd_pkg::PADS_PER_PORT]
                  : ~obcd_pkg::BOND_MAP_OTHER[p*obcd_pkg::PADS_PER_PORT +:
                                               obcd_pkg::PADS_PER_PORT];
            end
         end
      end
   endgenerate

   // Avalon-MM slave handshake
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         waitreq_r <= 1'b1;
      end else if (bus_req & waitreq_r) begin
         waitreq_r <= 1'b0;
      end else begin
         waitreq_r <= 1'b1;
      end
   end

   // Read data mux
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (i_avs_read & waitreq_r) begin
         rdata_r <= 32'h0000_0000;
         case (i_avs_address)
            obcd_pkg::ADDR_OPT_BYTE0: begin
               if (opt_access) begin
                  rdata_r[7:0] <= nv_byte_r[0];
               end
            end
            obcd_pkg::ADDR_OPT_BYTE1: begin
               if (opt_access) begin
                  rdata_r[7:0] <= nv_byte_r[1];
               end
            end
            obcd_pkg::ADDR_STATUS: begin
               rdata_r[obcd_pkg::ST_PROG_MODE] <= prog_sync_r;
               rdata_r[obcd_pkg::ST_ERASE_BUSY] <= erase_pending_r
                  | (state_r == obcd_pkg::SEQ_USER_ERASE)
                  | (state_r == obcd_pkg::SEQ_OPT_ERASE);
               rdata_r[obcd_pkg::ST_USER_ERASE] <= user_erase_r;
               rdata_r[obcd_pkg::ST_PROTECT] <= cfg_r.readout_protected;
               rdata_r[obcd_pkg::ST_RUNNING] <= (state_r == obcd_pkg::SEQ_RUN);
            end
            obcd_pkg::ADDR_APPLIED: begin
               rdata_r[$bits(obcd_pkg::obcd_cfg_t)-1:0] <= cfg_r;
            end
            default: begin
               rdata_r <= 32'h0000_0000;
            end
         endcase
      end
   end

   assign o_avs_readdata = rdata_r;
   assign o_avs_waitrequest = waitreq_r;
   assign o_cfg = cfg_r;
   assign o_cpu_reset_n = cpu_reset_n_r;
   assign o_halt_exit_wait = halt_wait_r;
   assign o_halt_watchdog_reset_select_reset = halt_watchdog_reset_select_rst_r;
   assign o_user_erase_req = user_erase_r;
   assign o_pad_pullup = pullup_r;

endmodule

// ==== sim/obcd_decoder_properties.sv ====
// Port checks for the option byte decoder
`timescale 1ns/10ps
module obcd_decoder_properties (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_prog_mode,
   input wire logic i_halt_entry,
   input wire logic i_wdg_running,
   input wire logic i_halt_exit,
   input wire logic i_user_erase_done,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire obcd_pkg::obcd_cfg_t o_cfg,
   input wire logic o_cpu_reset_n,
   input wire logic o_halt_exit_wait,
   input wire logic o_halt_watchdog_reset_select_reset,
   input wire logic o_user_erase_req,
   input wire logic [63:0] o_pad_pullup
);
   logic [12:0] wait_cnt_r;
   default clocking dcb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   // Halt-exit wait length
   always_ff @(posedge i_mclk) begin
      if (i_rst || !o_halt_exit_wait) begin
         wait_cnt_r <= 13'h0000;
      end else begin
         wait_cnt_r <= wait_cnt_r + 13'h0001;
      end
   end
   a_halt_wdg_reset: assert property (
      o_cpu_reset_n && i_halt_entry && i_wdg_running && o_cfg.halt_wdg_reset_en
      |=> o_halt_watchdog_reset_select_reset) else $error("halt reset pulse missing");
   a_halt_rst_cause: assert property (
      o_halt_watchdog_reset_select_reset |-> $past(i_halt_entry && i_wdg_running && o_cfg.halt_wdg_reset_en))
      else $error("halt reset pulse without cause");
   a_cfg_frozen: assert property (
      o_cpu_reset_n && $past(o_cpu_reset_n) |-> $stable(o_cfg))
      else $error("settings changed while running");
   a_pad_pullup: assert property (
      o_cpu_reset_n && $past(o_cpu_reset_n) |-> o_pad_pullup ==
      ~(o_cfg.package_80 ? obcd_pkg::BOND_MAP_80 : obcd_pkg::BOND_MAP_OTHER))
      else $error("pad pull-up map wrong");
   a_halt_wait_len: assert property (
      $fell(o_halt_exit_wait) |-> wait_cnt_r == (o_cfg.long_reset_delay ?
      obcd_pkg::RST_CYCLES_LONG : obcd_pkg::RST_CYCLES_SHORT))
      else $error("halt-exit delay length wrong");
   a_halt_wait_start: assert property (
      i_halt_exit && o_cpu_reset_n && !o_halt_exit_wait && !o_user_erase_req
      |=> o_halt_exit_wait) else $error("halt-exit delay not started");
   a_user_erase_end: assert property (
      o_user_erase_req && i_user_erase_done |-> ##[1:2] !o_user_erase_req)
      else $error("user erase request stuck");
   a_hidden_bytes: assert property (
      (!i_prog_mode) [*4] ##0 (i_avs_read && !o_avs_waitrequest &&
      i_avs_address <= obcd_pkg::ADDR_OPT_BYTE1) |-> o_avs_readdata == 32'h0)
      else $error("option byte visible outside programming");
endmodule
bind obcd_decoder obcd_decoder_properties u_props (
   .i_mclk(i_mclk),
   .i_rst(i_rst),
   .i_prog_mode(i_prog_mode),
   .i_halt_entry(i_halt_entry),
   .i_wdg_running(i_wdg_running),
   .i_halt_exit(i_halt_exit),
   .i_user_erase_done(i_user_erase_done),
   .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read),
   .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest),
   .o_cfg(o_cfg),
   .o_cpu_reset_n(o_cpu_reset_n),
   .o_halt_exit_wait(o_halt_exit_wait),
   .o_halt_watchdog_reset_select_reset(o_halt_watchdog_reset_select_reset),
   .o_user_erase_req(o_user_erase_req),
   .o_pad_pullup(o_pad_pullup)
);

// ==== sim/obcd_prog_tool.sv ====
// Programming tool model driving the option byte bus
`timescale 1ns/10ps
module obcd_prog_tool (
   input wire logic i_mclk,
   input wire logic i_waitrequest,
   output logic [4:0] o_address,
   output logic o_read,
   output logic o_write,
   output logic [31:0] o_writedata,
   output logic [3:0] o_byteenable
);
   initial begin
      o_address = 5'h1F;
      o_read = 1'b0;
      o_write = 1'b0;
      o_writedata = 32'h0;
      o_byteenable = 4'hF;
   end
   // One transfer, held until waitrequest low
   task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      o_address <= a;
      o_writedata <= d;
      o_read <= rd;
      o_write <= !rd;
      do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
      o_read <= 1'b0;
      o_write <= 1'b0;
      o_address <= ~a;
      o_writedata <= ~d;
   endtask
   task automatic prog(input logic [7:0] b0, input logic [7:0] b1,
      output logic [7:0] f0, output logic [7:0] f1);
      f0 = b0;
      f1 = b1;
      f0[5] = 1'b1;
      f0[2] = 1'b1;
      if (f0[4:3] != 2'h3) f0[0] = 1'b1;
      if (f1[5:4] == 2'h0) f1[6] = 1'b0;
      if (f1[5] || f1[3:1] != 3'h1) f1[0] = 1'b1;
      xfer(1'b0, obcd_pkg::ADDR_OPT_BYTE0, {24'h0, f0});
      xfer(1'b0, obcd_pkg::ADDR_OPT_BYTE1, {24'h0, f1});
   endtask
endmodule

// ==== sim/tb_top.sv ====
// Bench for the option byte decoder
`timescale 1ns/10ps
module tb_top;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic i_power_on = 1'b1;
   logic i_prog_mode = 1'b0;
   logic i_halt_entry = 1'b0;
   logic i_wdg_running = 1'b0;
   logic i_halt_exit = 1'b0;
   logic i_user_erase_done = 1'b0;
   logic [4:0] i_avs_address;
   logic i_avs_read;
   logic i_avs_write;
   logic [31:0] i_avs_writedata;
   logic [3:0] i_avs_byteenable;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest;
   obcd_pkg::obcd_cfg_t o_cfg;
   obcd_pkg::obcd_cfg_t cur;
   logic o_cpu_reset_n;
   logic o_halt_exit_wait;
   logic o_halt_watchdog_reset_select_reset;
   logic o_user_erase_req;
   logic [63:0] o_pad_pullup;
   logic [31:0] rd_q[$];
   logic [31:0] cfg_q[$];
   logic run_r = 1'b0;
   logic [7:0] b0;
   logic [7:0] b1;
   logic [7:0] f0;
   logic [7:0] f1;
   int n;
   int err_count = 0;
   int samples_checked = 0;
   int seed = 32'h29910AD2;

   always #25 i_mclk = ~i_mclk;

   obcd_decoder u_dut (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_power_on(i_power_on),
      .i_prog_mode(i_prog_mode),
      .i_halt_entry(i_halt_entry),
      .i_wdg_running(i_wdg_running),
      .i_halt_exit(i_halt_exit),
      .i_user_erase_done(i_user_erase_done),
      .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest),
      .o_cfg(o_cfg),
      .o_cpu_reset_n(o_cpu_reset_n),
      .o_halt_exit_wait(o_halt_exit_wait),
      .o_halt_watchdog_reset_select_reset(o_halt_watchdog_reset_select_reset),
      .o_user_erase_req(o_user_erase_req),
      .o_pad_pullup(o_pad_pullup)
   );
   obcd_prog_tool u_tool (
      .i_mclk(i_mclk),
      .i_waitrequest(o_avs_waitrequest),
      .o_address(i_avs_address),
      .o_read(i_avs_read),
      .o_write(i_avs_write),
      .o_writedata(i_avs_writedata),
      .o_byteenable(i_avs_byteenable)
   );

   function automatic obcd_pkg::obcd_cfg_t dec(input logic [7:0] a, input logic [7:0] b);
      return {a[7], ~a[6], a[4:3] != 2'h3, a[4:3], ~a[0], b[7], a[1],
         {b[7], a[1]} == 2'h3, ~b[6], b[5:4], b[3:1], ~b[0]};
   endfunction

   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", name, e, g);
      end
   endtask

   task automatic final_report();
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic rd_exp(input logic [4:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      u_tool.xfer(1'b1, a, 32'h0);
   endtask

   task automatic rst_seq(input logic [7:0] a, input logic [7:0] b);
      int d;
      d = b[6] ? 32'h100 : 32'h1000;
      cur = dec(a, b);
      cfg_q.push_back(32'(cur));
      i_rst <= 1'b1;
      repeat (5) @(posedge i_mclk);
      i_rst <= 1'b0;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_cpu_reset_n !== 1'b1 && n < 5000);
      chk("reset delay", 32'h1, 32'(n >= d && n <= d + 3));
   endtask

   // Result watcher
   always @(posedge i_mclk) begin
      if (i_avs_read && o_avs_waitrequest === 1'b0)
         chk("readdata", rd_q.pop_front(), o_avs_readdata);
      if (o_cpu_reset_n === 1'b1 && !run_r) begin
         chk("cfg", cfg_q.pop_front(), 32'(o_cfg));
         chk("pullup lo", {32{~cur.package_80}}, o_pad_pullup[31:0]);
         chk("pullup hi", {32{~cur.package_80}}, o_pad_pullup[63:32]);
      end
      run_r <= (o_cpu_reset_n === 1'b1);
   end

   initial begin
      repeat (60000) @(posedge i_mclk);
      err_count++;
      final_report();
   end

   initial begin
      rst_seq(8'hFF, 8'hFF);
      i_power_on <= 1'b0;
      rd_exp(obcd_pkg::ADDR_OPT_BYTE1, 32'h0);
      u_tool.xfer(1'b0, obcd_pkg::ADDR_OPT_BYTE1, 32'h0);
      i_prog_mode <= 1'b1;
      repeat (4) @(posedge i_mclk);
      rd_exp(obcd_pkg::ADDR_OPT_BYTE0, 32'hFF);
      rd_exp(obcd_pkg::ADDR_OPT_BYTE1, 32'hFF);
      for (int i = 0; i < 4; i++) begin
         b0 = 8'($random(seed));
         b1 = 8'($random(seed));
         b0[7] = i[0];
         b0[4:3] = i[1:0];
         b1[5:4] = i[1:0];
         b1[3:1] = 3'(i);
         u_tool.prog(b0, b1, f0, f1);
         rd_exp(obcd_pkg::ADDR_OPT_BYTE0, {24'h0, f0});
         rd_exp(obcd_pkg::ADDR_OPT_BYTE1, {24'h0, f1});
         rd_exp(obcd_pkg::ADDR_APPLIED, 32'(cur));
         rst_seq(f0, f1);
         rd_exp(obcd_pkg::ADDR_APPLIED, 32'(cur));
         i_halt_entry <= 1'b1;
         i_wdg_running <= 1'b1;
         @(posedge i_mclk);
         i_halt_entry <= 1'b0;
         i_halt_exit <= 1'b1;
         @(posedge i_mclk);
         i_halt_exit <= 1'b0;
         chk("halt reset", 32'(f0[7]), 32'(o_halt_watchdog_reset_select_reset));
         n = 0;
         do begin
            @(posedge i_mclk);
            n++;
         end while ((n < 3 || o_halt_exit_wait === 1'b1) && n < 5000);
         chk("halt wait", (f1[6] ? 32'h100 : 32'h1000) + 32'h1, 32'(n));
      end
      u_tool.prog(8'hFE, 8'hFF, f0, f1);
      u_tool.xfer(1'b0, obcd_pkg::ADDR_COMMAND, 32'h1);
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_user_erase_req !== 1'b1 && n < 20);
      chk("user erase", 32'h1, 32'(o_user_erase_req));
      rd_exp(obcd_pkg::ADDR_STATUS, {27'h0, 1'b0, cur.readout_protected, 3'h7});
      i_user_erase_done <= 1'b1;
      @(posedge i_mclk);
      i_user_erase_done <= 1'b0;
      repeat (4) @(posedge i_mclk);
      rd_exp(obcd_pkg::ADDR_OPT_BYTE0, 32'hFF);
      u_tool.prog(8'h00, 8'h00, f0, f1);
      u_tool.xfer(1'b0, obcd_pkg::ADDR_COMMAND, 32'h1);
      repeat (4) @(posedge i_mclk);
      rd_exp(obcd_pkg::ADDR_OPT_BYTE0, 32'hFF);
      rd_exp(obcd_pkg::ADDR_OPT_BYTE1, 32'hFF);
      @(posedge i_mclk);
      final_report();
   end
endmodule
